//--- design/opt_pkg.sv
// constants, enumerations and carrier structs of the one-shot pulse timer
package opt_pkg;

	// =========================================================
	// widths and reset values
	localparam int CNT_W = 8;
	localparam logic [7:0] PRIM_RST = 8'hFF;
	localparam logic [7:0] PRE_RST = 8'hFF;

	// =========================================================
	// count source timing, in master clocks
	localparam logic [2:0] DIV_RST = 3'h0;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	// half a count-source period, rounded up to a whole clock
	localparam logic [2:0] HALF_F1 = 3'h1;
	localparam logic [2:0] HALF_F2 = 3'h1;
	localparam logic [2:0] HALF_F8 = 3'h4;
	localparam logic [2:0] HALF_COMP = 3'h1;

	// =========================================================
	// enumerations
	typedef enum logic [1:0]
	{
		SRC_F1 = 2'b00,
		SRC_F2 = 2'b01,
		SRC_F8 = 2'b10,
		SRC_COMP = 2'b11
	} opt_src_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_TAIL = 2'b10
	} opt_state_t;

	// =========================================================
	// carrier structs
	typedef struct packed
	{
		opt_src_t src;
		logic count_enable_bit;
		logic pulse_mode;
		logic output_level_select_bit;
		logic gpio_level;
	} opt_tmr_cfg_t;

	typedef struct packed
	{
		logic pin_trigger_enable_bit;
		logic ext_irq_input_enable_bit;
		logic trigger_polarity_bit;
		logic both_edge_select_bit;
	} opt_pin_cfg_t;

endpackage

//--- design/opt_sync2.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module opt_sync2
#(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// data
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// =========================================================
	// the first stage feeds only the second stage
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

//--- design/opt_oneshot_timer.sv
// one-shot pulse mode of an 8-bit timer with prescaler
//
// Contract
// - count source is f1, f2, f8 or companion
// - underflow reloads, clears start bit; pulse ends with the timer irq
// - any stop reloads counters on the edge that halts
// - width is (prescaler+1)(primary+1) source periods
// - edges during pulse ignored, interrupt still raised
// - stop on reload, enable clear, start clear
// - timer interrupt half source cycle after underflow
// - output pin carries pulse; plain mode gives GPIO
// - trigger enable selects pin trigger role
// - reads return live counter values
// - writes update reload; counters take them at next reload
// - enabled writes reload only; else both
// - level select sets output pulse polarity
// - polarity bit selects active trigger edge
// - polarity bit matters only in single-edge mode
// - secondary period register unused in this mode
`timescale 1ns/100ps
module opt_oneshot_timer
#(
	parameter int CNT_W = opt_pkg::CNT_W
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// configuration bits
	input wire opt_pkg::opt_tmr_cfg_t i_tmr_cfg,
	input wire opt_pkg::opt_pin_cfg_t i_pin_cfg,
	// start bit write strobes and readback
	input wire logic i_start_set,
	input wire logic i_start_clr,
	output logic o_oneshot_start_bit,
	// counter register writes and live reads
	input wire logic i_primary_wr,
	input wire logic i_prescaler_wr,
	input wire logic [CNT_W-1:0] i_wr_data,
	output logic [CNT_W-1:0] o_primary_count,
	output logic [CNT_W-1:0] o_prescaler_count,
	// companion timer underflow, same clock
	input wire logic i_comp_uflow,
	// pins and interrupt requests
	input wire logic i_ext_trigger_pin,
	output logic o_pulse_out_pin,
	output logic o_ext_irq,
	output logic o_timer_irq
);

	// =========================================================
	// trigger pin synchroniser and edge selection
	logic pin_s;
	logic pin_prev_q;
	logic pin_rise, pin_fall, pin_edge, trig_ok;

	opt_sync2 #(.W(1)) u_pin_sync
	(
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_async(i_ext_trigger_pin),
		.o_sync(pin_s)
	);

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			pin_prev_q <= 1'b0;
		else
			pin_prev_q <= pin_s;
	end

	// polarity only picks an edge in single-edge mode
	always_comb
	begin
		pin_rise = pin_s & ~pin_prev_q;
		pin_fall = ~pin_s & pin_prev_q;
		if (i_pin_cfg.both_edge_select_bit)
			pin_edge = pin_rise | pin_fall;
		else if (i_pin_cfg.trigger_polarity_bit)
			pin_edge = pin_fall;
		else
			pin_edge = pin_rise;
		// the pin acts as trigger only with both enables high
		trig_ok = pin_edge & i_pin_cfg.pin_trigger_enable_bit
			& i_pin_cfg.ext_irq_input_enable_bit;
	end

	// =========================================================
	// count source ticks and half-period lengths
	logic [2:0] div_q;
	logic [2:0] div_d;
	logic tick;
	logic [2:0] half_len;

	always_comb
	begin
		div_d = div_q + 3'h1;
		case (i_tmr_cfg.src)
			opt_pkg::SRC_F1:
			begin
				tick = 1'b1;
				half_len = opt_pkg::HALF_F1;
			end
			opt_pkg::SRC_F2:
			begin
				tick = div_q[0];
				half_len = opt_pkg::HALF_F2;
			end
			opt_pkg::SRC_F8:
			begin
				tick = (div_q == opt_pkg::DIV8_LAST);
				half_len = opt_pkg::HALF_F8;
			end
			default:
			begin
				tick = i_comp_uflow;
				half_len = opt_pkg::HALF_COMP;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			div_q <= opt_pkg::DIV_RST;
		else
			div_q <= div_d;
	end

	// =========================================================
	// counters, reload registers and sequencer
	opt_pkg::opt_state_t state_q, state_d;
	logic [CNT_W-1:0] prim_q, prim_d, prim_rl_q, prim_rl_d;
	logic [CNT_W-1:0] pre_q, pre_d, pre_rl_q, pre_rl_d;
	logic [2:0] tail_q, tail_d;
	logic start_q, start_d;
	logic pin_q, pin_d;
	logic eirq_q, eirq_d;
	logic tirq_q, tirq_d;
	logic uflow;
	logic stop;

	always_comb
	begin
		state_d = state_q;
		prim_d = prim_q;
		pre_d = pre_q;
		prim_rl_d = prim_rl_q;
		pre_rl_d = pre_rl_q;
		tail_d = tail_q;
		start_d = start_q;
		tirq_d = 1'b0;
		uflow = 1'b0;
		stop = (state_q == opt_pkg::ST_RUN)
			&& (!i_tmr_cfg.count_enable_bit || i_start_clr);
		case (state_q)
			opt_pkg::ST_IDLE:
			begin
				// a start needs the count enable already high
				if (i_tmr_cfg.count_enable_bit && i_tmr_cfg.pulse_mode
					&& (i_start_set || trig_ok))
				begin
					state_d = opt_pkg::ST_RUN;
					start_d = 1'b1;
				end
			end
			opt_pkg::ST_RUN:
			begin
				if (stop)
				begin
					// reload and halt on the same clock edge
					prim_d = prim_rl_q;
					pre_d = pre_rl_q;
					start_d = 1'b0;
					state_d = opt_pkg::ST_IDLE;
				end
				else if (tick)
				begin
					if (pre_q != '0)
						pre_d = pre_q - 1'b1;
					else if (prim_q != '0)
					begin
						pre_d = pre_rl_q;
						prim_d = prim_q - 1'b1;
					end
					else
					begin
						// both primary and prescaler reloads take part
						uflow = 1'b1;
						prim_d = prim_rl_q;
						pre_d = pre_rl_q;
						start_d = 1'b0;
						tail_d = half_len - 3'h1;
						state_d = opt_pkg::ST_TAIL;
					end
				end
			end
			opt_pkg::ST_TAIL:
			begin
				// pulse ends and interrupt fires together
				if (tail_q == 3'h0)
				begin
					tirq_d = 1'b1;
					state_d = opt_pkg::ST_IDLE;
				end
				else
					tail_d = tail_q - 3'h1;
			end
			default:
			begin
				state_d = opt_pkg::ST_IDLE;
				start_d = 1'b0;
			end
		endcase
		// writes reach the counter only while count is disabled
		if (i_primary_wr)
		begin
			prim_rl_d = i_wr_data;
			if (!i_tmr_cfg.count_enable_bit)
				prim_d = i_wr_data;
		end
		if (i_prescaler_wr)
		begin
			pre_rl_d = i_wr_data;
			if (!i_tmr_cfg.count_enable_bit)
				pre_d = i_wr_data;
		end
		// interrupt still raised for ignored trigger edges
		eirq_d = pin_edge & i_pin_cfg.ext_irq_input_enable_bit;
		// GPIO in plain mode; pulse rises a clock late to offset the tail
		if (!i_tmr_cfg.pulse_mode)
			pin_d = i_tmr_cfg.gpio_level;
		else if (state_q != opt_pkg::ST_IDLE
			&& state_d != opt_pkg::ST_IDLE)
			pin_d = i_tmr_cfg.output_level_select_bit;
		else
			pin_d = ~i_tmr_cfg.output_level_select_bit;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q <= opt_pkg::ST_IDLE;
			prim_q <= opt_pkg::PRIM_RST;
			pre_q <= opt_pkg::PRE_RST;
			prim_rl_q <= opt_pkg::PRIM_RST;
			pre_rl_q <= opt_pkg::PRE_RST;
			tail_q <= 3'h0;
			start_q <= 1'b0;
			pin_q <= 1'b0;
			eirq_q <= 1'b0;
			tirq_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			prim_q <= prim_d;
			pre_q <= pre_d;
			prim_rl_q <= prim_rl_d;
			pre_rl_q <= pre_rl_d;
			tail_q <= tail_d;
			start_q <= start_d;
			pin_q <= pin_d;
			eirq_q <= eirq_d;
			tirq_q <= tirq_d;
		end
	end

	// =========================================================
	// outputs
	assign o_primary_count = prim_q;
	assign o_prescaler_count = pre_q;
	assign o_oneshot_start_bit = start_q;
	assign o_pulse_out_pin = pin_q;
	assign o_ext_irq = eirq_q;
	assign o_timer_irq = tirq_q;

	// =========================================================
	// assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	underflow_to_irq_a: assert property (
		uflow |-> ##[2:5] o_timer_irq)
		else $error("timer irq not raised after underflow");
	irq_ends_pulse_a: assert property (
		o_timer_irq |-> $past(state_q) == opt_pkg::ST_TAIL
			&& !o_oneshot_start_bit)
		else $error("timer irq without tail or start bit set");
	stop_reloads_a: assert property (
		(stop && !i_primary_wr) |=> state_q == opt_pkg::ST_IDLE
			&& prim_q == prim_rl_q)
		else $error("stop did not reload primary counter");
	enabled_write_a: assert property (
		(i_primary_wr && i_tmr_cfg.count_enable_bit && !uflow
			&& !stop) |=> prim_rl_q == $past(i_wr_data)
			&& (prim_q == $past(prim_q)
			|| prim_q == $past(prim_q) - 1'b1))
		else $error("enabled write reached the counter");
	idle_write_a: assert property (
		(i_prescaler_wr && !i_tmr_cfg.count_enable_bit)
		|=> pre_q == $past(i_wr_data) && pre_rl_q == $past(i_wr_data))
		else $error("disabled write missed counter or reload");
	prescale_step_a: assert property (
		(state_q == opt_pkg::ST_RUN && tick && pre_q != '0 && !stop
			&& !i_prescaler_wr) |=> pre_q == $past(pre_q) - 1'b1)
		else $error("prescaler did not decrement");
	busy_edge_irq_a: assert property (
		(state_q != opt_pkg::ST_IDLE && pin_edge
			&& i_pin_cfg.ext_irq_input_enable_bit) |=> o_ext_irq)
		else $error("pin irq lost during pulse");
	busy_ignore_a: assert property (
		(state_q == opt_pkg::ST_RUN && trig_ok && !stop && !uflow
			&& !i_primary_wr) |=> state_q == opt_pkg::ST_RUN
			&& (prim_q == $past(prim_q)
			|| prim_q == $past(prim_q) - 1'b1))
		else $error("trigger restarted a running pulse");
	pulse_level_a: assert property (
		(state_q != opt_pkg::ST_IDLE
			&& $past(state_q) != opt_pkg::ST_IDLE
			&& $past(i_tmr_cfg.pulse_mode))
		|-> o_pulse_out_pin == $past(i_tmr_cfg.output_level_select_bit))
		else $error("pulse level differs from level select");
	start_needs_enable_a: assert property (
		(state_q == opt_pkg::ST_IDLE && !i_tmr_cfg.count_enable_bit)
		|=> state_q == opt_pkg::ST_IDLE)
		else $error("pulse started with count disabled");
	sw_start_c: cover property (
		state_q == opt_pkg::ST_IDLE && i_start_set
			&& i_tmr_cfg.count_enable_bit && i_tmr_cfg.pulse_mode);
	pin_start_c: cover property (
		state_q == opt_pkg::ST_IDLE && trig_ok && !i_start_set
			&& i_tmr_cfg.count_enable_bit && i_tmr_cfg.pulse_mode);
	full_pulse_c: cover property (uflow ##[2:5] o_timer_irq);
	clear_stop_c: cover property (stop && i_start_clr);
endmodule

//--- tb/opt_far_side.sv
// far side model: trigger source on the pin and load of the pulse
`timescale 1ns/100ps
module opt_far_side
(
	// clock
	input wire logic i_mclk,
	// trigger command from the bench
	input wire logic i_trig_lvl,
	output logic o_trig,
	// pulse load
	input wire logic i_pin,
	input wire logic i_act,
	output logic [15:0] o_width
);
	logic was = 1'b0;
	// trigger line is a push-pull driver, always driven, never floats
	assign o_trig = i_trig_lvl;
	// load counts active cycles of the last pulse and holds the count
	always @(posedge i_mclk)
	begin
		if (i_pin == i_act)
			o_width <= was ? o_width + 16'h0001 : 16'h0001;
		was <= (i_pin == i_act);
	end
endmodule

//--- tb/opt_oneshot_timer_tb.sv
// self-checking bench of the one-shot pulse timer
`timescale 1ns/100ps
module opt_oneshot_timer_tb;
	// =========================================================
	// signals
	logic i_mclk, i_reset_n, st_set, st_clr, pwr, swr, comp, comp_on;
	logic trig_lvl, trig, start_bit, pout, eirq, tirq, lvl;
	opt_pkg::opt_tmr_cfg_t tcfg;
	opt_pkg::opt_pin_cfg_t pcfg;
	logic [7:0] wdata, prim, pre, gm, gn;
	logic [15:0] width;
	int err_total = 0, total_checks = 0, n_eirq = 0;
	assign lvl = tcfg.output_level_select_bit;
	// clock of 10 ns
	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// count pin interrupt pulses, they stand one cycle
	always @(posedge i_mclk)
		if (eirq === 1'b1)
			n_eirq <= n_eirq + 1;
	opt_oneshot_timer dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_tmr_cfg(tcfg), .i_pin_cfg(pcfg), .i_start_set(st_set),
		.i_start_clr(st_clr), .o_oneshot_start_bit(start_bit),
		.i_primary_wr(pwr), .i_prescaler_wr(swr), .i_wr_data(wdata),
		.o_primary_count(prim), .o_prescaler_count(pre),
		.i_comp_uflow(comp), .i_ext_trigger_pin(trig),
		.o_pulse_out_pin(pout), .o_ext_irq(eirq), .o_timer_irq(tirq));
	opt_far_side far (.i_mclk(i_mclk), .i_trig_lvl(trig_lvl),
		.o_trig(trig), .i_pin(pout), .i_act(lvl), .o_width(width));
	// =========================================================
	// shared tasks
	task print_verdict();
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// inputs move 1 ns after the edge; companion ticks on every other call
	task step(input int n);
		repeat (n) @(posedge i_mclk);
		#1 comp = comp_on & ~comp;
	endtask
	task wait_for(input logic want);
		int k;
		for (k = 0; k < 3000 && pout !== want; k++)
			step(1);
		if (k == 3000)
		begin
			err_total++;
			print_verdict();
		end
	endtask
	task wr(input logic sel, input logic [7:0] d);
		pwr = sel;
		swr = ~sel;
		wdata = d;
		step(1);
		pwr = 1'b0;
		swr = 1'b0;
		step(1);
	endtask
	// stopped writes load counter too; then enable counting
	task setup(input logic [7:0] n, input logic [7:0] m);
		tcfg.count_enable_bit = 1'b0;
		gm = m;
		gn = n;
		step(1);
		wr(1'b1, m);
		wr(1'b0, n);
		tcfg.count_enable_bit = 1'b1;
		step(1);
		check(prim, m);
		check(pre, n);
	endtask
	task kick();
		st_set = 1'b1;
		step(1);
		st_set = 1'b0;
	endtask
	task pulse(input logic [15:0] lo, input logic [15:0] hi);
		kick();
		check(start_bit, 1'b1);
		step(1);
		check(pout, lvl);
		wait_for(~lvl);
		check(tirq, 1'b1);
		check(start_bit, 1'b0);
		check({pre, prim}, {gn, gm});
		step(1);
		check((width >= lo) && (width <= hi), 1'b1);
	endtask
	// =========================================================
	// scenarios
	task wr_run();
		setup(8'h00, 8'h09);
		kick();
		step(2);
		wr(1'b1, 8'h03);
		check(prim, 8'h05);
		gm = 8'h03;
		wait_for(~lvl);
		step(1);
		check(prim, 8'h03);
		pulse(4, 4);
	endtask
	task stop_mid(input logic by_en);
		setup(8'h00, 8'h14);
		kick();
		step(5);
		check(prim, 8'h0F);
		if (by_en)
			tcfg.count_enable_bit = 1'b0;
		else
			st_clr = 1'b1;
		step(1);
		st_clr = 1'b0;
		check({start_bit, tirq, pout}, {2'b00, ~lvl});
		check({pre, prim}, 16'h0014);
	endtask
	task pin_start(input logic pol, input logic both, input logic ten);
		setup(8'h00, 8'h1E);
		trig_lvl = pol;
		step(4);
		pcfg = {1'b0, 1'b1, pol, both};
		step(4);
		pcfg.pin_trigger_enable_bit = ten;
		n_eirq = 0;
		trig_lvl = ~pol;
		if (!ten)
		begin
			step(8);
			check({start_bit, pout}, {1'b0, ~lvl});
			check(n_eirq, 1);
		end
		else
		begin
			wait_for(lvl);
			check(start_bit, 1'b1);
			trig_lvl = pol;
			step(4);
			trig_lvl = ~pol;
			step(4);
			wait_for(~lvl);
			step(1);
			check(width, 16'h001F);
			check(n_eirq, both ? 3 : 2);
		end
		tcfg.count_enable_bit = 1'b0;
		step(1);
		pcfg.pin_trigger_enable_bit = 1'b0;
	endtask
	// =========================================================
	// main sequence
	initial
	begin
		{st_set, st_clr, pwr, swr, comp, comp_on, trig_lvl} = 7'h00;
		wdata = 8'h00;
		tcfg = 6'h06;
		pcfg = 4'h0;
		i_reset_n = 1'b0;
		repeat (8) @(posedge i_mclk);
		#1 i_reset_n = 1'b1;
		step(1);
		check({pre, prim}, 16'hFFFF);
		check({start_bit, tirq, pout}, {2'b00, ~lvl});
		setup(8'h01, 8'h02);
		pulse(6, 6);
		setup(8'h00, 8'h00);
		pulse(1, 1);
		tcfg.output_level_select_bit = 1'b0;
		setup(8'h03, 8'h01);
		pulse(8, 8);
		tcfg.src = opt_pkg::SRC_F2;
		setup(8'h01, 8'h02);
		pulse(11, 14);
		tcfg.src = opt_pkg::SRC_F8;
		setup(8'h00, 8'h01);
		pulse(9, 20);
		tcfg.src = opt_pkg::SRC_COMP;
		comp_on = 1'b1;
		setup(8'h01, 8'h02);
		pulse(11, 14);
		comp_on = 1'b0;
		tcfg.src = opt_pkg::SRC_F1;
		wr_run();
		stop_mid(1'b0);
		stop_mid(1'b1);
		pin_start(1'b0, 1'b0, 1'b1);
		pin_start(1'b1, 1'b0, 1'b1);
		pin_start(1'b0, 1'b1, 1'b1);
		pin_start(1'b0, 1'b0, 1'b0);
		tcfg.pulse_mode = 1'b0;
		tcfg.gpio_level = 1'b1;
		step(2);
		check(pout, 1'b1);
		tcfg.gpio_level = 1'b0;
		step(2);
		check(pout, 1'b0);
		print_verdict();
	end
endmodule
